// file: hw/debug_port_defs.vh
// Purpose: constants for the debug port mode select block
// Assumes: core clock 125 MHz
// Notes: mode codes are {test_reset, emul_pin_one, emul_pin_zero} decoded
//
// Overview of operation
// - mode is chosen from test-reset and both emulation pin levels at power-up
// - chosen mode is active as soon as power-up reset releases
// - each test-reset rising edge latches emulate mode whatever the emulation pins read
// - decode: 00 slave, 01 test, 10 wait-in-reset, 11 normal; test-reset high emulates
// - slave mode disables processor and memory sections
// - wait-in-reset holds core reset until an external release
// - undriven pins default to test-reset low and emulation pins high
// - link is five scan signals plus two bidirectional emulation pins
// - halt on breakpoint, bus compare match, attention request, single step
// - report system reset, test reset, powerdown, missing clock or ready
// - report global interrupt enable and reason debug access is blocked
// - cycle counter covers three hours at 100 MHz without wrapping
// - memory and register access requests pass while the program runs
// - stop-mode halt ignores all interrupts including nmi and reset
`ifndef DEBUG_PORT_DEFS_VH
`define DEBUG_PORT_DEFS_VH
`define MODE_W          3
`define MODE_SLAVE      3'h0
`define MODE_TEST       3'h1
`define MODE_WAIT_RST   3'h2
`define MODE_NORMAL     3'h3
`define MODE_EMULATE    3'h4
// 3 h * 100 MHz = 1.08e12 cycles, needs 40 bits
`define CYC_CNT_W       40
`define STAT_W          8
`define ST_SYS_RST      0
`define ST_TEST_RST     1
`define ST_PWR_DOWN     2
`define ST_NO_CLK       3
`define ST_NO_READY     4
`define ST_INT_EN       5
`define ST_BLK_RUN      6
`define ST_BLK_DBGM     7
`endif

// file: hw/debug_port_mode_select.v
// Purpose: debug port front end: mode decode and latch, break and status logic
// Assumes: scan clock and pins sampled by clk through two flops
// Notes: no software registers; controls are plain ports
//        the pin chain keeps sampling through reset so the boot decode is valid
//        on the first edge after release
`include "debug_port_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module debug_port_mode_select (
    input  wire                    clk,
    input  wire                    sys_rst,
    input  wire                    test_reset,
    input  wire                    test_clock,
    input  wire                    test_mode_sel,
    input  wire                    test_data_in,
    output reg                     test_data_out,
    output reg                     test_clock_return,
    output reg                     presence_detect,
    input  wire                    emul_pin_zero_in,
    output reg                     emul_pin_zero_out,
    output reg                     emul_pin_zero_oe,
    input  wire                    emul_pin_one_in,
    output reg                     emul_pin_one_out,
    output reg                     emul_pin_one_oe,
    input  wire                    pin_pull_ok,
    input  wire                    core_reset_in,
    input  wire                    wait_release,
    input  wire                    sw_breakpoint,
    input  wire                    bus_match,
    input  wire                    attention_req,
    input  wire                    single_step,
    input  wire                    run_req,
    input  wire                    stop_mode,
    input  wire                    powerdown,
    input  wire                    sys_clk_alive,
    input  wire                    mem_ready_alive,
    input  wire                    global_int_en,
    input  wire                    dbgm_set,
    input  wire                    instr_done,
    input  wire                    irq_req,
    input  wire                    mem_access_req,
    output reg                     mem_access_grant,
    output reg  [`MODE_W-1:0]      op_mode,
    output reg                     core_disable,
    output reg                     core_reset_out,
    output reg                     halted,
    output reg                     irq_accept,
    output reg  [`STAT_W-1:0]      dbg_status,
    output reg  [`CYC_CNT_W-1:0]   cycle_count
);
    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // bit positions inside the synchroniser word
    localparam SB_RSTIN = 0;
    localparam SB_TDI   = 1;
    localparam SB_TCK   = 3;
    localparam SB_TRST  = 4;
    localparam SB_EMUL_PIN_ZERO  = 5;
    localparam SB_EMUL_PIN_ONE  = 6;
    reg [6:0] sync_a;
    reg [6:0] sync_b;
    // no reset on purpose: the chain keeps sampling while sys_rst is high,
    // so the power-up decode sees settled pin levels, not stale defaults
    always @(posedge clk) begin
        sync_a <= {emul_pin_one_in, emul_pin_zero_in, test_reset, test_clock,
                   test_mode_sel, test_data_in, core_reset_in};
        sync_b <= sync_a;
    end
    // undriven pins fall back to defaults when pulls are not trusted
    wire s_emul_pin_one  = pin_pull_ok ? sync_b[SB_EMUL_PIN_ONE] : 1'b1;
    wire s_emul_pin_zero  = pin_pull_ok ? sync_b[SB_EMUL_PIN_ZERO] : 1'b1;
    wire s_trst  = pin_pull_ok ? sync_b[SB_TRST] : 1'b0;
    wire s_tck   = sync_b[SB_TCK];
    wire s_tdi   = sync_b[SB_TDI];
    wire s_rstin = sync_b[SB_RSTIN];

    function [`MODE_W-1:0] decode;
        input t;
        input e1;
        input e0;
        begin
            if (t) begin
                decode = `MODE_EMULATE;
            end else begin
                case ({e1, e0})
                    2'b00:   decode = `MODE_SLAVE;
                    2'b01:   decode = `MODE_TEST;
                    2'b10:   decode = `MODE_WAIT_RST;
                    default: decode = `MODE_NORMAL;
                endcase
            end
        end
    endfunction

    // ==========================================================
    // mode latch
    // ==========================================================
    reg       trst_q;
    reg       boot_done;
    reg       wait_hold;
    reg       tck_q;
    wire      trst_rise = s_trst & ~trst_q;
    wire      wait_boot = ({s_emul_pin_one, s_emul_pin_zero} == 2'b10) && !s_trst;

    // edge history of test reset and scan clock; both idle low, so the
    // reset value cannot fake an edge on the first cycle
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            trst_q <= 1'b0;
            tck_q  <= 1'b0;
        end else begin
            trst_q <= s_trst;
            tck_q  <= s_tck;
        end
    end

    // first edge after power-up reset takes the pin mode at once; later
    // only a test reset rise moves it, so emulation pin traffic while
    // emulating never disturbs the latched mode
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_done <= 1'b0;
            op_mode   <= `MODE_NORMAL;
        end else begin
            boot_done <= 1'b1;
            if (!boot_done) begin
                op_mode <= decode(s_trst, s_emul_pin_one, s_emul_pin_zero);
            end else if (trst_rise) begin
                op_mode <= decode(1'b1, s_emul_pin_one, s_emul_pin_zero);
            end
        end
    end

    // wait-in-reset only arises at power-up; an external release ends it
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_hold <= 1'b0;
        end else if (!boot_done) begin
            wait_hold <= wait_boot;
        end else if (wait_release) begin
            wait_hold <= 1'b0;
        end
    end

    // ==========================================================
    // core control and break
    // ==========================================================
    // break causes act only in emulate mode; other boots ignore them
    wire brk = sw_breakpoint | bus_match | attention_req;
    reg  stepping;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_disable     <= 1'b0;
            core_reset_out   <= 1'b1;
            halted           <= 1'b0;
            stepping         <= 1'b0;
            irq_accept       <= 1'b0;
            mem_access_grant <= 1'b0;
            cycle_count      <= {`CYC_CNT_W{1'b0}};
        end else begin
            core_disable   <= (op_mode == `MODE_SLAVE);
            // stop-mode halt masks the reset pin as well; the boot edge keeps
            // reset up so wait mode never shows a one-cycle release
            core_reset_out <= ~boot_done | wait_hold | (s_rstin & ~(halted & stop_mode));
            if (halted) begin
                if (single_step) begin
                    halted   <= 1'b0;
                    stepping <= 1'b1;
                end else if (run_req) begin
                    halted <= 1'b0;
                end
            end else if (stepping) begin
                if (instr_done) begin
                    halted   <= 1'b1;
                    stepping <= 1'b0;
                end
            end else if (brk && op_mode == `MODE_EMULATE) begin
                halted <= 1'b1;
            end
            irq_accept       <= irq_req & ~(halted & stop_mode);
            // slave mode hands memory to the other processor, so no grant
            mem_access_grant <= mem_access_req & ~core_disable;
            // 40 bits hold three hours at 100 MHz; a wrap is not flagged
            if (!halted && !core_reset_out)
                cycle_count <= cycle_count + 1'b1;
        end
    end

    // ==========================================================
    // status and link outputs
    // ==========================================================
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dbg_status        <= {`STAT_W{1'b0}};
            test_data_out     <= 1'b0;
            test_clock_return <= 1'b0;
            presence_detect   <= 1'b0;
            emul_pin_zero_out <= 1'b0;
            emul_pin_zero_oe  <= 1'b0;
            emul_pin_one_out  <= 1'b0;
            emul_pin_one_oe   <= 1'b0;
        end else begin
            dbg_status[`ST_SYS_RST]  <= s_rstin;
            dbg_status[`ST_TEST_RST] <= ~s_trst;
            dbg_status[`ST_PWR_DOWN] <= powerdown;
            dbg_status[`ST_NO_CLK]   <= ~sys_clk_alive;
            dbg_status[`ST_NO_READY] <= ~mem_ready_alive;
            dbg_status[`ST_INT_EN]   <= global_int_en;
            dbg_status[`ST_BLK_RUN]  <= ~halted;
            dbg_status[`ST_BLK_DBGM] <= dbgm_set;
            // high once out of reset: tells the pod the target is powered
            presence_detect   <= 1'b1;
            test_clock_return <= s_tck;
            // simple bypass path shifted on scan clock rising edge
            if (s_tck && !tck_q)
                test_data_out <= s_tdi;
            // emulation pins are driven low for the whole halt, only when emulating
            emul_pin_zero_oe  <= (op_mode == `MODE_EMULATE);
            emul_pin_one_oe   <= (op_mode == `MODE_EMULATE);
            emul_pin_zero_out <= ~halted;
            emul_pin_one_out  <= ~halted;
        end
    end
endmodule // debug_port_mode_select
`default_nettype wire

// file: verification/dpm_checker.sv
// Purpose: port checker for debug_port_mode_select
// Assumes: one clock domain, clk
// Notes: bound to the design top
`timescale 1ns/1ps
`default_nettype none
module dpm_checker (
    input wire        clk,
    input wire        sys_rst,
    input wire        test_reset,
    input wire        sw_breakpoint,
    input wire        powerdown,
    input wire        emul_pin_zero_oe,
    input wire        core_disable,
    input wire        core_reset_out,
    input wire        halted,
    input wire [2:0]  op_mode,
    input wire [7:0]  dbg_status,
    input wire [39:0] cycle_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_emu; $rose(test_reset) |-> ##[2:5] op_mode == 3'h4; endproperty
    a_emu: assert property (p_emu) else $error("emulate mode late");
    // first edge after reset is the power-up decode, so excluded
    property p_hold; !$past(sys_rst, 2) && $past(op_mode) != 3'h2 && op_mode != $past(op_mode)
        |-> op_mode == 3'h4; endproperty
    a_hold: assert property (p_hold) else $error("mode moved");
    property p_slave; op_mode == 3'h0 |-> ##[0:1] core_disable; endproperty
    a_slave: assert property (p_slave) else $error("slave not disabled");
    property p_oe; op_mode == 3'h4 |-> ##[0:1] emul_pin_zero_oe; endproperty
    a_oe: assert property (p_oe) else $error("pin not driven");
    property p_brk; op_mode == 3'h4 && sw_breakpoint |=> halted; endproperty
    a_brk: assert property (p_brk) else $error("no halt");
    property p_cyc; halted [*2] |=> $stable(cycle_count); endproperty
    a_cyc: assert property (p_cyc) else $error("count ran halted");
    property p_wait; $rose(op_mode == 3'h2) |-> core_reset_out [*3]; endproperty
    a_wait: assert property (p_wait) else $error("wait reset dropped");
    property p_pwr; powerdown [*3] |-> dbg_status[2]; endproperty
    a_pwr: assert property (p_pwr) else $error("powerdown unseen");
    c_halt: cover property (op_mode == 3'h4 && halted);
    c_wait: cover property ($rose(op_mode == 3'h2));
    c_slave: cover property (core_disable);
endmodule // dpm_checker
bind debug_port_mode_select dpm_checker i_dpm_checker (.clk, .sys_rst, .test_reset,
    .sw_breakpoint, .powerdown, .emul_pin_zero_oe, .core_disable, .core_reset_out,
    .halted, .op_mode, .dbg_status, .cycle_count);
`default_nettype wire

// file: verification/scan_pod.sv
// Purpose: scan controller pod model on the debug link
// Assumes: emulation pins float high when nobody drives them
// Notes: test clock stands still while test reset is low
`timescale 1ns/1ps
`default_nettype none
module scan_pod (
    input  wire       trst_req,
    input  wire       emu_drive,
    input  wire [1:0] emu_req,
    input  wire [1:0] dev_out,
    input  wire [1:0] dev_oe,
    output reg        test_clock,
    output wire       test_reset,
    output wire [1:0] emu_pin
);
    // quarter-ns phase keeps every edge clear of the core clock edges
    initial begin
        test_clock = 1'b0;
        #0.25;
        forever #62.5 test_clock = trst_req ? ~test_clock : 1'b0;
    end
    assign test_reset = trst_req;
    // pod pins are inputs once the device drives them
    assign emu_pin[0] = dev_oe[0] ? dev_out[0] : (emu_drive ? emu_req[0] : 1'b1);
    assign emu_pin[1] = dev_oe[1] ? dev_out[1] : (emu_drive ? emu_req[1] : 1'b1);
endmodule // scan_pod
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: self-checking bench for debug_port_mode_select
// Assumes: 125 MHz core clock, pod model on the link
// Notes: mode results checked through a queue of expectations
`include "debug_port_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    reg         clk = 1'b0, sys_rst = 1'b1, trst = 1'b0, pull = 1'b1, wrel = 1'b0, run = 1'b0;
    reg         mchk = 1'b0;
    reg  [2:0]  tq = 3'h0;
    reg  [1:0]  emu = 2'h3;
    reg  [2:0]  brk = 3'h0;
    reg  [31:0] seed = 32'h9610dff2, rv = 32'h0;
    reg  [39:0] cc;
    reg  [2:0]  exp_q[$];
    integer     fails = 0, num_checks = 0, i;
    wire        tclk, tr, zoe, ooe, zo, oo, halted, cdis, crst, tcr, pdet;
    wire [7:0]  dstat;
    wire [1:0]  pin;
    wire [2:0]  op_mode;
    wire [39:0] cycle_count;
    always #4 clk = ~clk;
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    always @(posedge clk) begin
        seed <= xs(seed);
        rv <= seed;
        tq <= {tq[1:0], tclk};
    end
    scan_pod i_scan_pod (.trst_req(trst), .emu_drive(1'b1), .emu_req(emu), .dev_out({oo, zo}),
        .dev_oe({ooe, zoe}), .test_clock(tclk), .test_reset(tr), .emu_pin(pin));
    debug_port_mode_select i_debug_port_mode_select (.clk(clk), .sys_rst(sys_rst),
        .test_reset(tr), .test_clock(tclk), .test_mode_sel(rv[0]), .test_data_in(rv[1]),
        .test_data_out(), .test_clock_return(tcr), .presence_detect(pdet), .emul_pin_zero_in(pin[0]),
        .emul_pin_zero_out(zo), .emul_pin_zero_oe(zoe), .emul_pin_one_in(pin[1]),
        .emul_pin_one_out(oo), .emul_pin_one_oe(ooe), .pin_pull_ok(pull), .core_reset_in(1'b0),
        .wait_release(wrel), .sw_breakpoint(brk[0]), .bus_match(brk[1]), .attention_req(brk[2]),
        .single_step(1'b0), .run_req(run), .stop_mode(rv[3]), .powerdown(rv[4]),
        .sys_clk_alive(rv[5]), .mem_ready_alive(rv[6]), .global_int_en(rv[7]), .dbgm_set(rv[8]),
        .instr_done(1'b0), .irq_req(rv[9]), .mem_access_req(rv[10]), .mem_access_grant(),
        .op_mode(op_mode), .core_disable(cdis), .core_reset_out(crst), .halted(halted),
        .irq_accept(), .dbg_status(dstat), .cycle_count(cycle_count));
    task chk(input [39:0] seen, input [39:0] want);
        begin
            num_checks = num_checks + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (fails == 0 && num_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    always @(negedge clk) if (mchk) chk(op_mode, exp_q.pop_front());
    task note(input [2:0] m);
        begin
            exp_q.push_back(m);
            mchk <= 1'b1;
            @(posedge clk);
            mchk <= 1'b0;
        end
    endtask
    task boot(input p, input [1:0] e);
        begin
            pull <= p;
            emu <= e;
            sys_rst <= 1'b1;
            repeat (8) @(posedge clk);
            sys_rst <= 1'b0;
            emu <= 2'h3;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        @(posedge clk);
        boot(1'b0, 2'h0);
        note(`MODE_NORMAL);
        for (i = 0; i < 4; i = i + 1) begin
            boot(1'b1, i[1:0]);
            note(i[2:0]);
            @(negedge clk);
            chk(cdis, i == 0);
            if (i == 2) begin
                chk(crst, 1'b1);
                @(posedge clk);
                wrel <= 1'b1;
                repeat (5) @(posedge clk);
                wrel <= 1'b0;
                @(negedge clk);
                chk(crst, 1'b0);
            end
            @(posedge clk);
        end
        emu <= 2'h0;
        repeat (5) @(posedge clk);
        note(`MODE_NORMAL);
        trst <= 1'b1;
        repeat (5) @(posedge clk);
        note(`MODE_EMULATE);
        for (i = 0; i < 3; i = i + 1) begin
            brk <= 3'h1 << i[1:0];
            @(posedge clk);
            brk <= 3'h0;
            repeat (3) @(negedge clk);
            cc = cycle_count;
            chk(halted, 1'b1);
            chk(dstat[`ST_BLK_RUN], 1'b0);
            chk(pin, 2'h0);
            @(negedge clk);
            chk(cycle_count, cc);
            @(posedge clk);
            run <= 1'b1;
            @(posedge clk);
            run <= 1'b0;
            repeat (4) @(negedge clk);
            chk(halted, 1'b0);
            chk(dstat[`ST_BLK_RUN], 1'b1);
            chk(dstat[`ST_TEST_RST], 1'b0);
            chk(pin, 2'h3);
            chk(tcr, tq[2]);
            chk(pdet, 1'b1);
            @(posedge clk);
        end
        tally_and_finish;
    end
    initial begin
        #20000;
        fails = fails + 1;
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
